/* File: tb.sv */
`timescale 1ns/10ps

// ------------------------------
// Sequencer bench
// ------------------------------
module tb;
    localparam int LD = 4;
    localparam int SF = 20;
    logic clk_sys, srst, lockout, in_reg, en, cap;
    logic rail, boost, gate, loading, init_wr, wiper_wr, bus_error;
    logic [7:0] nv, init_val, wiper, scale, ramp, wr_data;
    int err_count = 0;
    int num_checks = 0;

    vcs_sequencer #(.LOAD_CYCLES(LD), .SOFT_CYCLES(SF)) uut (
        .clk_sys(clk_sys), .srst(srst), .undervoltage_lockout(lockout),
        .logic_rail_in_reg(in_reg), .boost_enable_in(en), .gate_delay_cap_voltage(cap),
        .nv_code(nv), .init_wr(init_wr), .wiper_wr(wiper_wr), .wr_data(wr_data),
        .bus_error(bus_error), .initial_value_register(init_val), .wiper_code(wiper),
        .sink_scale(scale), .logic_supply_rail(rail), .rail_ramp(ramp),
        .boost_on(boost), .gate_pulse_output(gate), .loading(loading)
    );
    vcs_bus_host host (.clk_sys(clk_sys), .init_wr(init_wr), .wiper_wr(wiper_wr),
        .wr_data(wr_data), .bus_error(bus_error));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic probe(input int s);
        case (s)
            0: return loading;
            1: return rail;
            2: return boost;
            3: return gate;
            default: return ramp === 8'hff;
        endcase
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic await(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (probe(s) !== v && n < lim) begin
            tick(1);
            n++;
        end
        chk({7'h0, probe(s)}, {7'h0, v}, "wait ran out");
        if (probe(s) !== v) begin
            wrap_up();
        end
    endtask

    task automatic hold(input int s, input logic v, input int cyc);
        repeat (cyc) begin
            tick(1);
            chk({7'h0, probe(s)}, {7'h0, v}, "output moved early");
        end
    endtask

    task automatic reset_values();
        chk(init_val, 8'h80, "initial value after reset");
        chk(wiper, 8'h80, "wiper after reset");
        chk(scale, 8'h7f, "sink scale after reset");
        hold(1, 1'b0, 3);
        host.send(1'b1, 1'b0, 1'b0, 8'h11, 0);
        tick(1);
        chk(init_val, 8'h80, "write taken while off");
    endtask

    task automatic power_up(input logic [7:0] code);
        int n;
        n = 0;
        @(posedge clk_sys);
        nv <= code;
        lockout <= 1'b0;
        await(0, 1'b1, 3);
        while (loading === 1'b1 && n < 100) begin
            chk({7'h0, rail}, 8'h00, "rail on during load");
            tick(1);
            n++;
        end
        chk(8'(n), 8'(LD), "load length");
        await(1, 1'b1, 2);
        chk(ramp, 8'h00, "ramp not starting from zero");
        chk(init_val, code, "initial value not loaded");
        chk(wiper, code, "wiper not loaded");
        tick(1);
        chk(scale, 8'hff - code, "sink scale");
        hold(2, 1'b0, 5);
        await(4, 1'b1, SF * 10 + 40);
    endtask

    task automatic boost_gate();
        @(posedge clk_sys);
        in_reg <= 1'b1;
        await(2, 1'b1, 3);
        hold(3, 1'b0, 5);
        @(posedge clk_sys);
        cap <= 1'b1;
        await(3, 1'b1, 3);
        @(posedge clk_sys);
        en <= 1'b0;
        await(2, 1'b0, 3);
        await(3, 1'b0, 2);
        @(posedge clk_sys);
        en <= 1'b1;
        await(2, 1'b1, 3);
    endtask

    task automatic writes();
        logic [7:0] keep;
        keep = init_val;
        host.send(1'b0, 1'b1, 1'b0, 8'h10, 0);
        tick(1);
        chk(wiper, 8'h10, "wiper write");
        chk(scale, 8'hef, "scale after write");
        chk(init_val, keep, "wiper write moved initial value");
        host.send(1'b1, 1'b0, 1'b0, 8'ha5, 3);
        tick(1);
        chk(init_val, 8'ha5, "initial value write");
        chk(wiper, 8'ha5, "wiper not written with it");
        host.send(1'b0, 1'b0, 1'b1, 8'h00, 0);
        tick(1);
        chk(wiper, 8'h80, "error fallback");
        chk(init_val, 8'ha5, "error touched initial value");
        host.send(1'b0, 1'b1, 1'b0, 8'h22, 0);
        host.send(1'b0, 1'b1, 1'b1, 8'h33, 0);
        tick(1);
        chk(wiper, 8'h80, "error beside write");
    endtask

    task automatic power_down();
        @(posedge clk_sys);
        lockout <= 1'b1;
        await(1, 1'b0, 2);
        await(2, 1'b0, 1);
        await(3, 1'b0, 1);
        @(posedge clk_sys);
        in_reg <= 1'b0;
        cap <= 1'b0;
    endtask

    initial begin
        srst = 1'b1;
        lockout = 1'b1;
        in_reg = 1'b0;
        en = 1'b1;
        cap = 1'b0;
        nv = 8'h3c;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        tick(1);
        reset_values();
        power_up(8'h3c);
        boost_gate();
        writes();
        power_down();
        power_up(8'hc5);
        wrap_up();
    end
endmodule // tb

/* File: vcs_bus_host.sv */
`timescale 1ns/10ps

// ------------------------------
// Bus host model
// ------------------------------
module vcs_bus_host (
    // Clock
    input wire logic clk_sys,
    // Register access
    output logic init_wr,
    output logic wiper_wr,
    output logic [7:0] wr_data,
    output logic bus_error
);
    initial begin
        init_wr = 1'b0;
        wiper_wr = 1'b0;
        wr_data = 8'h00;
        bus_error = 1'b0;
    end

    // Idle data shows the inverse byte, so a stale value cannot pass for a write.
    task automatic send(input logic iw, input logic ww, input logic er,
                        input logic [7:0] d, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        init_wr <= iw;
        wiper_wr <= ww;
        bus_error <= er;
        wr_data <= d;
        @(posedge clk_sys);
        init_wr <= 1'b0;
        wiper_wr <= 1'b0;
        bus_error <= 1'b0;
        wr_data <= ~d;
    endtask
endmodule // vcs_bus_host

/* File: vcs_pkg.sv */
package vcs_pkg;
    typedef enum logic [5:0] {
        VCS_OFF = 6'h01,
        VCS_LOAD = 6'h02,
        VCS_SOFT = 6'h04,
        VCS_WAIT_EN = 6'h08,
        VCS_BOOST = 6'h10,
        VCS_RUN = 6'h20
    } vcs_state_t;
endpackage

/* File: vcs_regs.svh */
`ifndef VCS_REGS_SVH
`define VCS_REGS_SVH

// ----------------------------------------------------------------
// Calibration code
// ----------------------------------------------------------------
`define VCS_CODE_W 8
`define VCS_CODE_DEFAULT 8'h80
`define VCS_CODE_FULL 9'h0ff
`define VCS_CODE_STEPS 10'h100
`define VCS_SCALE_RESET 8'h7f

// ----------------------------------------------------------------
// Soft-start ramp
// ----------------------------------------------------------------
`define VCS_RAMP_ZERO 8'h00
`define VCS_RAMP_FULL 8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VCS_CLK_HZ 10000000
`define VCS_LOAD_TIME_US 120
`define VCS_SOFTSTART_TIME_US 500
`define VCS_LOAD_CYCLES ((`VCS_LOAD_TIME_US * (`VCS_CLK_HZ / 1000000)))
`define VCS_SOFTSTART_CYCLES ((`VCS_SOFTSTART_TIME_US * (`VCS_CLK_HZ / 1000000)))
`define VCS_TICK_DIV 10

`endif

/* File: vcs_sequencer.sv */
`timescale 1ns/10ps
`include "vcs_regs.svh"

// Contract
// - Calibration code is 8 bits; sink scale is 255 minus code over 256.
// - Calibration setting starts at 128.
// - Any bus transaction error forces working wiper back to 128; the code ignores errors in OFF and LOAD.
// - After lockout release, spend 120 us loading stored settings first.
// - Enable logic rail only after load, ramped over 0.5 ms soft-start.
// - Boost runs only while logic rail regulates and enable input is high.
// - Gate pulse output held low until delay cap reaches threshold.
// - Writing initial-value register also writes the working wiper.
module vcs_sequencer
    import vcs_pkg::*;
#(
    parameter int LOAD_CYCLES = `VCS_LOAD_CYCLES,
    parameter int SOFT_CYCLES = `VCS_SOFTSTART_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Supply and analog status
    input wire logic undervoltage_lockout,
    input wire logic logic_rail_in_reg,
    input wire logic boost_enable_in,
    input wire logic gate_delay_cap_voltage,
    // Stored code
    input wire logic [7:0] nv_code,
    // Bus-side register access
    input wire logic init_wr,
    input wire logic wiper_wr,
    input wire logic [7:0] wr_data,
    input wire logic bus_error,
    // Outputs
    output logic [7:0] initial_value_register,
    output logic [7:0] wiper_code,
    output logic [7:0] sink_scale,
    output logic logic_supply_rail,
    output logic [7:0] rail_ramp,
    output logic boost_on,
    output logic gate_pulse_output,
    output logic loading
);
    typedef struct packed {
        vcs_state_t st;
        logic [15:0] cnt;
        logic [7:0] init_val;
        logic [7:0] wiper;
        logic [7:0] scale;
        logic rail;
        logic [7:0] ramp;
        logic boost;
        logic gpo;
        logic load;
    } vcs_state_s_t;

    vcs_state_s_t s_q, s_d;
    logic tick;
    logic [8:0] inv_code;

    // The step counter is 16 bits wide, so longer intervals cannot be timed.
    if (LOAD_CYCLES < 1 || SOFT_CYCLES < 1 ||
        LOAD_CYCLES > 65535 || SOFT_CYCLES > 65535) begin : g_bad_timing
        $error("Timing counts out of range");
    end

    // ----------------------------------------------------------------
    // Ramp step divider
    // ----------------------------------------------------------------
    vcs_tick_div #(.DIV(`VCS_TICK_DIV)) u_div (
        .clk_sys(clk_sys),
        .srst(srst),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        inv_code = 9'h000;
        case (s_q.st)
            VCS_OFF: begin
                s_d.cnt = '0;
                if (!undervoltage_lockout) begin
                    s_d.st = VCS_LOAD;
                    s_d.load = 1'b1;
                end
            end
            VCS_LOAD: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                s_d.init_val = nv_code;
                s_d.wiper = nv_code;
                if (s_q.cnt == 16'(LOAD_CYCLES - 1)) begin
                    s_d.st = VCS_SOFT;
                    s_d.cnt = '0;
                    s_d.load = 1'b0;
                    s_d.rail = 1'b1;
                end
            end
            VCS_SOFT: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                s_d.ramp = 8'((32'(s_q.cnt) * 32'(`VCS_RAMP_FULL)) / SOFT_CYCLES);
                if (s_q.cnt == 16'(SOFT_CYCLES - 1)) begin
                    s_d.st = VCS_WAIT_EN;
                    s_d.ramp = `VCS_RAMP_FULL;
                end
            end
            VCS_WAIT_EN: begin
                if (logic_rail_in_reg && boost_enable_in) begin
                    s_d.st = VCS_BOOST;
                    s_d.boost = 1'b1;
                end
            end
            VCS_BOOST, VCS_RUN: begin
                if (!(logic_rail_in_reg && boost_enable_in)) begin
                    s_d.st = VCS_WAIT_EN;
                    s_d.boost = 1'b0;
                    s_d.gpo = 1'b0;
                end else if (gate_delay_cap_voltage) begin
                    s_d.st = VCS_RUN;
                    s_d.gpo = 1'b1;
                end
            end
            default: begin
                s_d.st = VCS_OFF;
            end
        endcase
        if (s_q.st != VCS_LOAD && s_q.st != VCS_OFF) begin
            if (init_wr) begin
                s_d.init_val = wr_data;
                s_d.wiper = wr_data;
            end else if (wiper_wr) begin
                s_d.wiper = wr_data;
            end
            if (bus_error) begin
                s_d.wiper = `VCS_CODE_DEFAULT;
            end
        end
        inv_code = `VCS_CODE_FULL - {1'b0, s_d.wiper};
        s_d.scale = inv_code[7:0];
        if (undervoltage_lockout) begin
            s_d.st = VCS_OFF;
            s_d.rail = 1'b0;
            s_d.boost = 1'b0;
            s_d.gpo = 1'b0;
            s_d.load = 1'b0;
        end
        // ramp follows state
        // Keyed on the next state, so the ramp starts from zero as the rail turns on
        // and a lockout in mid-ramp clears it together with the rail.
        if (s_d.st != VCS_SOFT) begin
            s_d.ramp = s_d.rail ? `VCS_RAMP_FULL : `VCS_RAMP_ZERO;
        end else if (!tick) begin
            s_d.ramp = s_q.ramp;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
            s_q.st <= VCS_OFF;
            s_q.init_val <= `VCS_CODE_DEFAULT;
            s_q.wiper <= `VCS_CODE_DEFAULT;
            s_q.scale <= `VCS_SCALE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign initial_value_register = s_q.init_val;
    assign wiper_code = s_q.wiper;
    assign sink_scale = s_q.scale;
    assign logic_supply_rail = s_q.rail;
    assign rail_ramp = s_q.ramp;
    assign boost_on = s_q.boost;
    assign gate_pulse_output = s_q.gpo;
    assign loading = s_q.load;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // scale tracks wiper
    a_scale_match: assert property (@(posedge clk_sys) disable iff (srst)
        {1'b0, s_q.scale} == `VCS_CODE_FULL - {1'b0, s_q.wiper})
        else $error("sink scale mismatch");
    a_reset_default: assert property (@(posedge clk_sys)
        $fell(srst) |-> s_q.wiper == `VCS_CODE_DEFAULT && s_q.init_val == `VCS_CODE_DEFAULT)
        else $error("reset default wrong");
    a_error_fallback: assert property (@(posedge clk_sys)
        disable iff (srst || undervoltage_lockout)
        bus_error && s_q.st inside {VCS_SOFT, VCS_WAIT_EN, VCS_BOOST, VCS_RUN}
        |=> s_q.wiper == `VCS_CODE_DEFAULT) else $error("error fallback missing");
    a_load_no_rail: assert property (@(posedge clk_sys) disable iff (srst)
        s_q.st == VCS_LOAD |-> !s_q.rail && !s_q.boost) else $error("rail during load");
    a_rail_after_load: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(s_q.rail) |-> $past(s_q.st) == VCS_LOAD) else $error("rail early");
    a_ramp_start: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(s_q.rail) |-> s_q.ramp == `VCS_RAMP_ZERO) else $error("ramp not from zero");
    a_boost_gate: assert property (@(posedge clk_sys) disable iff (srst)
        s_q.boost |-> $past(logic_rail_in_reg) && $past(boost_enable_in))
        else $error("boost without conditions");
    a_gate_hold: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(s_q.gpo) |-> $past(gate_delay_cap_voltage)) else $error("gate early");
    a_init_pair: assert property (@(posedge clk_sys)
        disable iff (srst || undervoltage_lockout)
        init_wr && !bus_error && s_q.st inside {VCS_SOFT, VCS_WAIT_EN, VCS_BOOST, VCS_RUN}
        |=> s_q.wiper == $past(wr_data) && s_q.init_val == $past(wr_data))
        else $error("paired write lost");
    a_load_copy: assert property (@(posedge clk_sys)
        disable iff (srst || undervoltage_lockout)
        s_q.st == VCS_LOAD |=> s_q.init_val == $past(nv_code)) else $error("load copy missing");

    c_boost_up: cover property (@(posedge clk_sys) disable iff (srst) $rose(s_q.boost));
    c_gate_up: cover property (@(posedge clk_sys) disable iff (srst) $rose(s_q.gpo));
    c_bus_err: cover property (@(posedge clk_sys) disable iff (srst) bus_error && s_q.st == VCS_RUN);
endmodule // vcs_sequencer

/* File: vcs_tick_div.sv */
`timescale 1ns/10ps
`include "vcs_regs.svh"

module vcs_tick_div #(
    parameter int DIV = `VCS_TICK_DIV
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Tick
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } vcs_div_t;

    vcs_div_t s_q, s_d;

    if (DIV < 2 || DIV > 256) begin : g_bad_div
        $error("DIV out of range");
    end

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 8'(DIV - 1)) begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule // vcs_tick_div
